// [logic/dqt_pkg.sv]
// dqt_pkg: constants, layouts and states for the dq termination control block
// assumes: apb register access on pclk, 32-bit data, word-aligned offsets
`default_nettype none
package dqt_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] DQT_MODE_OFS = 8'h00;
  localparam logic [7:0] DQT_CFG_OFS = 8'h04;
  localparam logic [7:0] DQT_CMD_OFS = 8'h08;
  localparam logic [7:0] DQT_STAT_OFS = 8'h0C;
  // mode register: termination code field
  localparam int DQT_CODE_LSB = 0;
  localparam int DQT_CODE_W = 3;
  localparam logic [2:0] DQT_CODE_OFF = 3'h0;
  localparam logic [2:0] DQT_CODE_MAX = 3'h6;
  // config register fields
  localparam int DQT_CFG_BIN_LSB = 0;
  localparam int DQT_CFG_SETB_BIT = 4;
  localparam int DQT_CFG_BL32_BIT = 5;
  localparam int DQT_CFG_PD_BIT = 8;
  localparam int DQT_CFG_SR_BIT = 9;
  localparam int DQT_CFG_WL_BIT = 10;
  localparam int DQT_CFG_W = 11;
  // command register fields (write only, one pulse per write)
  localparam int DQT_CMD_WR1_BIT = 0;
  localparam int DQT_CMD_MWR1_BIT = 1;
  localparam int DQT_CMD_FIFO_BIT = 2;
  localparam int DQT_CMD_CAS2_BIT = 3;
  // pin counts
  localparam int DQT_DQ_W = 16;
  localparam int DQT_DMI_W = 2;
  localparam int DQT_DQS_W = 2;
  // latency table, indexed by speed bin 0..7 (low bins undefined)
  localparam logic [2:0] DQT_BIN_FIRST = 3'h2;
  localparam logic [7:0] DQT_ON_A [8] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h04, 8'h06, 8'h06, 8'h08};
  localparam logic [7:0] DQT_ON_B [8] = '{8'h00, 8'h00, 8'h06, 8'h0C, 8'h0E, 8'h12, 8'h14, 8'h18};
  localparam logic [7:0] DQT_OFF_A [8] = '{8'h00, 8'h00, 8'h00, 8'h14, 8'h16, 8'h18, 8'h1A, 8'h1C};
  localparam logic [7:0] DQT_OFF_B [8] = '{8'h00, 8'h00, 8'h16, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C};
  localparam logic [7:0] DQT_BL32_ADD = 8'h08;
  localparam logic [7:0] DQT_CNT_ONE = 8'h01;
  typedef enum logic [1:0]
  {
    DQT_IDLE = 2'b00,
    DQT_ARMED = 2'b01,
    DQT_WAIT = 2'b10,
    DQT_ON = 2'b11
  } dqt_state_t;
endpackage
`default_nettype wire

// [logic/dqt_ctrl.sv]
// dqt_ctrl: on-die termination control for data, strobe and mask pins
// assumes: apb master on pclk; link clock and cke come from another domain
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`default_nettype none
// Functional notes
// - a termination code of 1 to 6 enables data-bus termination.
// - a zero code disables termination and it is never applied.
// - the non-zero code selects strength from 240 ohm (code 1) to 40 ohm (code 6).
// - with termination enabled, data pins stay high impedance outside a write burst.
// - a write-1, mask write-1 or write-fifo command arms termination automatically.
// - termination switches off once the burst write has completed.
// - turn-on latency is counted in link clocks from the second cas command.
// - turn-off latency is counted in link clocks from the second cas command.
// - latencies come from a table by speed bin and write-latency set; low bins are undefined.
// - a 32-beat burst adds 8 clocks to the turn-off latency.
// - power-down keeps termination off whatever the code.
// - in self refresh termination follows cke high with a code of 1 to 6, off when cke low.
// - write leveling with a code of 1 to 6 terminates the strobe pins continuously.
// - write leveling keeps data and mask pin termination off.
// - each data, strobe and mask pin has its own enable driven only by internal logic.
module dqt_ctrl
  import dqt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_clk,
  input wire logic cke,
  output logic [DQT_DQ_W-1:0] dq_term_en,
  output logic [DQT_DMI_W-1:0] dmi_term_en,
  output logic [DQT_DQS_W-1:0] dqs_term_en,
  output logic [DQT_CODE_W-1:0] term_strength
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [DQT_CODE_W-1:0] code;
    logic [DQT_CFG_W-1:0] cfg;
    logic [1:0] lclk_sync;
    logic lclk_prev;
    logic [1:0] cke_sync;
    dqt_state_t state;
    logic [7:0] cnt;
    logic [7:0] on_lat;
    logic [7:0] off_lat;
    logic cas_err;
    logic [DQT_DQ_W-1:0] dq_en;
    logic [DQT_DMI_W-1:0] dmi_en;
    logic [DQT_DQS_W-1:0] dqs_en;
    logic [DQT_CODE_W-1:0] strength;
  } dqt_regs_t;
  dqt_regs_t r_ff;
  dqt_regs_t nxt_r;
  logic enabled_c;
  logic win_c;
  logic [DQT_DQ_W-1:0] nxt_dq_en;
  logic [DQT_DMI_W-1:0] nxt_dmi_en;
  logic [DQT_DQS_W-1:0] nxt_dqs_en;
  // ==========================================================
  // shared enable terms
  assign enabled_c = (r_ff.code != DQT_CODE_OFF) && (r_ff.code <= DQT_CODE_MAX);
  assign win_c = (r_ff.state == DQT_ON) && enabled_c;
  // ==========================================================
  // pin group enables
  dqt_pin_sel
  #(
    .WIDTH(DQT_DQ_W),
    .LEVEL_ON(1'b0)
  )
  u_dq_sel
  (
    .win(win_c),
    .enabled(enabled_c),
    .cke_hi(r_ff.cke_sync[1]),
    .sr_mode(r_ff.cfg[DQT_CFG_SR_BIT]),
    .wl_mode(r_ff.cfg[DQT_CFG_WL_BIT]),
    .pd_mode(r_ff.cfg[DQT_CFG_PD_BIT]),
    .en(nxt_dq_en)
  );
  dqt_pin_sel
  #(
    .WIDTH(DQT_DMI_W),
    .LEVEL_ON(1'b0)
  )
  u_dmi_sel
  (
    .win(win_c),
    .enabled(enabled_c),
    .cke_hi(r_ff.cke_sync[1]),
    .sr_mode(r_ff.cfg[DQT_CFG_SR_BIT]),
    .wl_mode(r_ff.cfg[DQT_CFG_WL_BIT]),
    .pd_mode(r_ff.cfg[DQT_CFG_PD_BIT]),
    .en(nxt_dmi_en)
  );
  dqt_pin_sel
  #(
    .WIDTH(DQT_DQS_W),
    .LEVEL_ON(1'b1)
  )
  u_dqs_sel
  (
    .win(win_c),
    .enabled(enabled_c),
    .cke_hi(r_ff.cke_sync[1]),
    .sr_mode(r_ff.cfg[DQT_CFG_SR_BIT]),
    .wl_mode(r_ff.cfg[DQT_CFG_WL_BIT]),
    .pd_mode(r_ff.cfg[DQT_CFG_PD_BIT]),
    .en(nxt_dqs_en)
  );
  // ==========================================================
  // next state
  always_comb
  begin
    logic wr;
    logic rd;
    logic cmd_wr;
    logic arm;
    logic cas2;
    logic edge_l;
    logic enabled;
    logic [7:0] cnt_inc;
    logic [2:0] bin;
    logic [7:0] on_l;
    logic [7:0] off_l;
    wr = 1'b0;
    rd = 1'b0;
    cmd_wr = 1'b0;
    arm = 1'b0;
    cas2 = 1'b0;
    edge_l = 1'b0;
    enabled = 1'b0;
    cnt_inc = 8'h00;
    bin = 3'h0;
    on_l = 8'h00;
    off_l = 8'h00;
    nxt_r = r_ff;
    // apb slave, one wait state: pready rises in the second access cycle
    nxt_r.pready = 1'b0;
    nxt_r.pslverr = 1'b0;
    if (psel && penable && !r_ff.pready)
    begin
      nxt_r.pready = 1'b1;
      wr = pwrite;
      rd = !pwrite;
      nxt_r.prdata = 32'h0000_0000;
      case (paddr)
        DQT_MODE_OFS:
        begin
          if (wr)
            nxt_r.code = pwdata[DQT_CODE_LSB +: DQT_CODE_W];
          else
            nxt_r.prdata[DQT_CODE_LSB +: DQT_CODE_W] = r_ff.code;
        end
        DQT_CFG_OFS:
        begin
          if (wr)
            nxt_r.cfg = pwdata[DQT_CFG_W-1:0];
          else
            nxt_r.prdata[DQT_CFG_W-1:0] = r_ff.cfg;
        end
        DQT_CMD_OFS:
        begin
          cmd_wr = wr;
        end
        DQT_STAT_OFS:
        begin
          if (wr)
            nxt_r.pslverr = 1'b1;
          else
            nxt_r.prdata = {20'h00000, r_ff.cas_err, r_ff.state, r_ff.cnt, r_ff.dqs_en[0]};
        end
        default:
        begin
          nxt_r.pslverr = 1'b1;
        end
      endcase
    end
    // command decode
    arm = cmd_wr && (pwdata[DQT_CMD_WR1_BIT] || pwdata[DQT_CMD_MWR1_BIT]
      || pwdata[DQT_CMD_FIFO_BIT]);
    cas2 = cmd_wr && pwdata[DQT_CMD_CAS2_BIT];
    // link clock and cke synchronisers, edge found after second stage
    nxt_r.lclk_sync = {r_ff.lclk_sync[0], link_clk};
    nxt_r.cke_sync = {r_ff.cke_sync[0], cke};
    nxt_r.lclk_prev = r_ff.lclk_sync[1];
    edge_l = r_ff.lclk_sync[1] && !r_ff.lclk_prev;
    // latency lookup
    bin = r_ff.cfg[DQT_CFG_BIN_LSB +: 3];
    on_l = r_ff.cfg[DQT_CFG_SETB_BIT] ? DQT_ON_B[bin] : DQT_ON_A[bin];
    off_l = r_ff.cfg[DQT_CFG_SETB_BIT] ? DQT_OFF_B[bin] : DQT_OFF_A[bin];
    if (r_ff.cfg[DQT_CFG_BL32_BIT])
      off_l = 8'(off_l + DQT_BL32_ADD);
    enabled = enabled_c;
    cnt_inc = 8'(r_ff.cnt + DQT_CNT_ONE);
    // burst window machine
    case (r_ff.state)
      DQT_IDLE:
      begin
        if (arm && enabled)
          nxt_r.state = DQT_ARMED;
      end
      DQT_ARMED:
      begin
        if (cas2)
        begin
          if (on_l == 8'h00)
          begin
            nxt_r.cas_err = 1'b1;
            nxt_r.state = DQT_IDLE;
          end
          else
          begin
            nxt_r.cas_err = 1'b0;
            nxt_r.on_lat = on_l;
            nxt_r.off_lat = off_l;
            nxt_r.cnt = 8'h00;
            nxt_r.state = DQT_WAIT;
          end
        end
      end
      DQT_WAIT:
      begin
        if (edge_l)
        begin
          nxt_r.cnt = cnt_inc;
          if (cnt_inc >= r_ff.on_lat)
            nxt_r.state = DQT_ON;
        end
      end
      DQT_ON:
      begin
        if (edge_l)
        begin
          nxt_r.cnt = cnt_inc;
          if (cnt_inc >= r_ff.off_lat)
            nxt_r.state = DQT_IDLE;
        end
      end
      default:
      begin
        nxt_r.state = DQT_IDLE;
      end
    endcase
    if (!enabled)
      nxt_r.state = DQT_IDLE;
    // pin enables, priority power-down > write leveling > self refresh > window
    nxt_r.dq_en = nxt_dq_en;
    nxt_r.dmi_en = nxt_dmi_en;
    nxt_r.dqs_en = nxt_dqs_en;
    nxt_r.strength = enabled ? r_ff.code : DQT_CODE_OFF;
  end
  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      r_ff <= '0;
    else
      r_ff <= nxt_r;
  end
  assign prdata = r_ff.prdata;
  assign pready = r_ff.pready;
  assign pslverr = r_ff.pslverr;
  assign dq_term_en = r_ff.dq_en;
  assign dmi_term_en = r_ff.dmi_en;
  assign dqs_term_en = r_ff.dqs_en;
  assign term_strength = r_ff.strength;
endmodule

// ==========================================================
// enable select for one pin group
module dqt_pin_sel
#(
  parameter int WIDTH = 1,
  parameter bit LEVEL_ON = 1'b0
)
(
  input wire logic win,
  input wire logic enabled,
  input wire logic cke_hi,
  input wire logic sr_mode,
  input wire logic wl_mode,
  input wire logic pd_mode,
  output logic [WIDTH-1:0] en
);
  always_comb
  begin
    en = {WIDTH{win}};
    if (sr_mode)
      en = {WIDTH{enabled && cke_hi}};
    if (wl_mode)
      en = {WIDTH{LEVEL_ON && enabled}};
    if (pd_mode)
      en = '0;
  end
endmodule
`default_nettype wire

// [tb/dqt_ctrl_checker.sv]
// dqt_ctrl_checker: port assertions for dqt_ctrl
// assumes: bound to dqt_ctrl, one pclk domain
`default_nettype none
module dqt_ctrl_checker
  import dqt_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [DQT_DQ_W-1:0] dq_term_en,
  input wire logic [DQT_DMI_W-1:0] dmi_term_en,
  input wire logic [DQT_DQS_W-1:0] dqs_term_en,
  input wire logic [DQT_CODE_W-1:0] term_strength
);
  // ==========================================
  // sequences
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_wait;
    psel && penable && !pready;
  endsequence
  sequence s_open;
    $rose(dq_term_en[0]);
  endsequence
  // ==========================================
  // assertions
  a_one_wait: assert property (s_wait |=> pready) else $error("late");
  a_ready_pulse: assert property (pready |=> !pready) else $error("long");
  a_err_ready: assert property (pslverr |-> pready && psel && penable) else $error("err");
  a_zero_off: assert property (term_strength == 3'h0 |-> dq_term_en == '0 && dqs_term_en == '0)
    else $error("zero");
  a_code_max: assert property (term_strength <= DQT_CODE_MAX) else $error("max");
  a_code_hold: assert property (dq_term_en[0] && $past(dq_term_en[0]) |-> $stable(term_strength))
    else $error("hold");
  a_pins_same: assert property (dq_term_en == {DQT_DQ_W{dq_term_en[0]}}
    && dmi_term_en == {DQT_DMI_W{dq_term_en[0]}}) else $error("pins");
  a_dq_dqs: assert property (dq_term_en[0] |-> dqs_term_en == 2'h3) else $error("dqs");
  a_window_min: assert property (s_open |=> dq_term_en[0] [*8]) else $error("short");
endmodule
bind dqt_ctrl dqt_ctrl_checker u_chk(.pclk, .presetn, .psel, .penable, .pready, .pslverr, .dq_term_en,
  .dmi_term_en, .dqs_term_en, .term_strength);
`default_nettype wire

// [tb/dqt_mc_model.sv]
// dqt_mc_model: controller side, free memory clock and cke
// assumes: bench asks for the cke level
`default_nettype none
module dqt_mc_model
(
  input wire logic cke_req,
  output logic link_clk,
  output logic cke
);
  timeunit 1ns;
  timeprecision 1ns;
  assign cke = cke_req;
  initial
  begin
    link_clk = 1'h0;
    #37;
    forever #200 link_clk = ~link_clk;
  end
endmodule
`default_nettype wire

// [tb/test_dq_termination_control.sv]
// test_dq_termination_control: self-checking bench for dqt_ctrl
// assumes: dqt_mc_model makes the memory clock; bench is apb master
`default_nettype none
module test_dq_termination_control import dqt_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, link_clk, cke, cke_req, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [DQT_DQ_W-1:0] dq_term_en;
  logic [DQT_DMI_W-1:0] dmi_term_en;
  logic [DQT_DQS_W-1:0] dqs_term_en;
  logic [DQT_CODE_W-1:0] term_strength;
  int bad_count, checked, cyc, kon, koff, b, s, l, c;
  int lon[2][8] = '{'{0, 0, 0, 4, 4, 6, 6, 8}, '{0, 0, 6, 12, 14, 18, 20, 24}};
  int loff[2][8] = '{'{0, 0, 0, 20, 22, 24, 26, 28}, '{0, 0, 22, 28, 32, 36, 40, 44}};
  int mcf[5] = '{32'h107, 32'h207, 32'h207, 32'h2, 32'h7};
  int mcd[5] = '{3, 3, 3, 3, 0};
  int mon[5] = '{-1, -1, 0, -1, -1};
  dqt_ctrl dut(.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .link_clk, .cke, .dq_term_en, .dmi_term_en, .dqs_term_en, .term_strength);
  dqt_mc_model mc(.cke_req, .link_clk, .cke);
  // ==========================================
  // clock, timeout, tasks
  initial
  begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      finish_test();
    end
  end
  function automatic int fz(int e, int g);
    return (g >= e - 1 && g <= e + 1 && (g < 0) == (e < 0)) ? e : g;
  endfunction
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task burst(input logic [31:0] cf, input logic [31:0] cd);
    logic lp;
    int k;
    apb(1'h1, DQT_CFG_OFS, cf);
    apb(1'h1, DQT_MODE_OFS, cd);
    apb(1'h1, DQT_CMD_OFS, 32'h1 << $urandom_range(2, 0));
    apb(1'h1, DQT_CMD_OFS, 32'h8);
    kon = -1;
    koff = -1;
    k = 0;
    lp = link_clk;
    repeat (600)
    begin
      @(posedge pclk);
      k += (link_clk && !lp);
      lp = link_clk;
      if (kon < 0 && dq_term_en[0] === 1'h1)
      begin
        kon = k;
        chk("strength", cd, term_strength);
        chk("dqs", 2'h3, dqs_term_en);
      end
      if (kon >= 0 && koff < 0 && dq_term_en[0] !== 1'h1)
        koff = k;
    end
  endtask
  task finish_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================
  // tests
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, cke_req, presetn} = '0;
    {bad_count, checked} = '0;
    void'($urandom(32'hF46E));
    cke_req = 1'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, DQT_MODE_OFS, 32'h0);
    chk("mode_rst", 32'h0, rd);
    chk("dq_rst", 32'h0, dq_term_en);
    apb(1'h0, 8'h10, 32'h0);
    chk("unmapped", 32'h1, er);
    apb(1'h1, DQT_STAT_OFS, 32'hF);
    chk("stat_ro", 32'h1, er);
    apb(1'h1, DQT_CFG_OFS, 32'h735);
    apb(1'h0, DQT_CFG_OFS, 32'h0);
    chk("cfg_rb", 32'h735, rd);
    chk("cfg_err", 32'h0, er);
    $display("register test done");
    repeat (6)
    begin
      s = $urandom_range(1, 0);
      b = $urandom_range(7, 3 - s);
      l = $urandom_range(1, 0);
      c = $urandom_range(6, 1);
      burst(b | s << 4 | l << 5, c);
      apb(1'h0, DQT_MODE_OFS, 32'h0);
      chk("code", c, rd[2:0]);
      chk("on_lat", lon[s][b], fz(lon[s][b], kon));
      chk("off_lat", loff[s][b] + 8 * l, fz(loff[s][b] + 8 * l, koff));
    end
    $display("burst test done");
    for (int i = 0; i < 5; i++)
    begin
      cke_req <= (i != 1);
      burst(mcf[i], mcd[i]);
      chk("mode_on", mon[i], fz(mon[i], kon));
    end
    apb(1'h0, DQT_STAT_OFS, 32'h0);
    chk("cas_err", 32'h1, rd[11]);
    $display("power mode test done");
    apb(1'h1, DQT_CFG_OFS, 32'h400);
    apb(1'h1, DQT_MODE_OFS, 32'h3);
    repeat (10) @(posedge pclk);
    chk("wl_dqs", 2'h3, dqs_term_en);
    chk("wl_dq", 32'h0, {dq_term_en, dmi_term_en});
    apb(1'h1, DQT_MODE_OFS, 32'h0);
    repeat (10) @(posedge pclk);
    chk("wl_off", 2'h0, dqs_term_en);
    $display("leveling test done");
    finish_test();
  end
endmodule
`default_nettype wire
